/* File: rtl/iprio_pkg.sv */
package iprio_pkg;

    // ------------------------------------------------------------
    // register indices (word offsets on the plain register port)
    // ------------------------------------------------------------
    localparam logic [2:0] OFS_COMPARE_CAPTURE_A = 3'h0;
    localparam logic [2:0] OFS_PARALLEL_COMPARE = 3'h1;
    localparam logic [2:0] OFS_SECOND_I2C = 3'h2;
    localparam logic [2:0] OFS_EXTERNAL_PINS_B = 3'h3;
    localparam logic [2:0] OFS_CALENDAR_CLOCK = 3'h4;
    localparam logic [2:0] OFS_CRC_UART_ERRORS = 3'h5;
    localparam logic [2:0] OFS_LOW_VOLTAGE = 3'h6;

    // ------------------------------------------------------------
    // field positions (low bit of each 3-bit field)
    // ------------------------------------------------------------
    localparam int POS_HIGH = 12;   // bits 14-12
    localparam int POS_MID = 8;     // bits 10-8
    localparam int POS_LOW = 4;     // bits 6-4
    localparam int POS_BASE = 0;    // bits 2-0

    // implemented-bit masks per register
    localparam logic [15:0] MASK_FOUR = 16'h7777;
    localparam logic [15:0] MASK_LOW_PAIR = 16'h0077;
    localparam logic [15:0] MASK_MID_LOW = 16'h0770;
    localparam logic [15:0] MASK_MID = 16'h0700;
    localparam logic [15:0] MASK_THREE_UPPER = 16'h7770;
    localparam logic [15:0] MASK_BASE = 16'h0007;

    // every field resets to level 4
    localparam logic [2:0] LEVEL_RESET = 3'h4;
    localparam logic [2:0] LEVEL_OFF = 3'h0;
    localparam logic [15:0] RESET_ALL = 16'h4444;

endpackage

/* File: rtl/iprio_regs.sv */
// Operation
// - field 111 means level 7, highest
// - field 001 is level 1, linear up
// - field 000 disables the source entirely
// - unimplemented bits read zero, ignore writes
// - calendar priority in bits 10-8 only
// - crc 14-12, serial2 10-8, serial1 6-4
// - all fields reset to level 4
//
// Local design decisions: the address map and the plain strobed port.
module iprio_regs (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [2:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdData,
    // raw request per source, from the peripherals (same clock)
    input wire logic [15:0] srcRequest,
    // level per source to arbitration, 0 means not presented
    output logic [47:0] srcLevel,
    output logic [15:0] srcActive
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [15:0] bank_r [7];      // one word per register index
    logic [15:0] bank_nxt [7];    // next values
    logic [15:0] rdData_r;        // read answer register
    logic [15:0] rdData_nxt;

    // implemented-bit mask per index; index order follows the package
    function automatic logic [15:0] regMask(input logic [2:0] idx);
        case (idx)
            iprio_pkg::OFS_COMPARE_CAPTURE_A: regMask = iprio_pkg::MASK_FOUR;
            iprio_pkg::OFS_PARALLEL_COMPARE: regMask = iprio_pkg::MASK_LOW_PAIR;
            iprio_pkg::OFS_SECOND_I2C: regMask = iprio_pkg::MASK_MID_LOW;
            iprio_pkg::OFS_EXTERNAL_PINS_B: regMask = iprio_pkg::MASK_MID_LOW;
            iprio_pkg::OFS_CALENDAR_CLOCK: regMask = iprio_pkg::MASK_MID;
            iprio_pkg::OFS_CRC_UART_ERRORS: regMask = iprio_pkg::MASK_THREE_UPPER;
            iprio_pkg::OFS_LOW_VOLTAGE: regMask = iprio_pkg::MASK_BASE;
            default: regMask = 16'h0000;  // unmapped index holds nothing
        endcase
    endfunction

    // ------------------------------------------------------------
    // write and read path
    // ------------------------------------------------------------
    // writes land only on implemented bits; others stay zero
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            bank_nxt[i] = bank_r[i];
            if (regWrite && regAddr == 3'(i)) begin
                bank_nxt[i] = regWrData & regMask(3'(i));
            end
        end
        rdData_nxt = 16'h0000;
        if (regRead && regAddr != 3'h7) begin
            rdData_nxt = bank_r[regAddr] & regMask(regAddr);
        end
    end

    // reset loads level 4 into every implemented field
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 7; i++) begin
                bank_r[i] <= iprio_pkg::RESET_ALL & regMask(3'(i));
            end
            rdData_r <= 16'h0000;
        end else begin
            for (int i = 0; i < 7; i++) begin
                bank_r[i] <= bank_nxt[i];
            end
            rdData_r <= rdData_nxt;
        end
    end

    assign regRdData = rdData_r;

    // ------------------------------------------------------------
    // fields to arbitration
    // ------------------------------------------------------------
    // source order: 0 ic6, 1 oc5, 2 oc6, 3 oc7, 4 oc8, 5 pmp,
    // 6 i2c2 slave, 7 i2c2 master, 8 int3, 9 int4, 10 calendar,
    // 11 serial1 err, 12 serial2 err, 13 crc err, 14 lvd, 15 spare
    logic [2:0] lvl [16];
    always_comb begin
        lvl[0] = bank_r[0][iprio_pkg::POS_BASE +: 3];
        lvl[1] = bank_r[0][iprio_pkg::POS_LOW +: 3];
        lvl[2] = bank_r[0][iprio_pkg::POS_MID +: 3];
        lvl[3] = bank_r[0][iprio_pkg::POS_HIGH +: 3];
        lvl[4] = bank_r[1][iprio_pkg::POS_BASE +: 3];
        lvl[5] = bank_r[1][iprio_pkg::POS_LOW +: 3];
        lvl[6] = bank_r[2][iprio_pkg::POS_LOW +: 3];
        lvl[7] = bank_r[2][iprio_pkg::POS_MID +: 3];
        lvl[8] = bank_r[3][iprio_pkg::POS_LOW +: 3];
        lvl[9] = bank_r[3][iprio_pkg::POS_MID +: 3];
        lvl[10] = bank_r[4][iprio_pkg::POS_MID +: 3];
        lvl[11] = bank_r[5][iprio_pkg::POS_LOW +: 3];
        lvl[12] = bank_r[5][iprio_pkg::POS_MID +: 3];
        lvl[13] = bank_r[5][iprio_pkg::POS_HIGH +: 3];
        lvl[14] = bank_r[6][iprio_pkg::POS_BASE +: 3];
        lvl[15] = iprio_pkg::LEVEL_OFF;  // spare slot never presented
    end

    // level code is the priority itself: 7 highest, 1 lowest, 0 off
    always_comb begin
        for (int s = 0; s < 16; s++) begin
            srcLevel[s*3 +: 3] = lvl[s];
            srcActive[s] = srcRequest[s] && (lvl[s] != iprio_pkg::LEVEL_OFF);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // write strobe on the calendar index
    sequence s_write_cal;
        regWrite && regAddr == iprio_pkg::OFS_CALENDAR_CLOCK;
    endsequence

    // read strobe on the calendar index
    sequence s_read_cal;
        regRead && regAddr == iprio_pkg::OFS_CALENDAR_CLOCK;
    endsequence

    // level-not-off per source, rebuilt from the outputs for the gating check
    logic [15:0] levelOn;
    always_comb begin
        levelOn = 16'h0000;
        for (int s = 0; s < 16; s++) begin
            levelOn[s] = srcLevel[s*3 +: 3] != 3'h0;
        end
    end

    a_disabled_silent: assert property (
        srcLevel[41:39] == 3'h0 |-> !srcActive[13])
        else $error("disabled crc source presented");
    a_level_seven: assert property (
        (regWrite && regAddr == iprio_pkg::OFS_LOW_VOLTAGE && regWrData[2:0] == 3'h7)
        |=> srcLevel[44:42] == 3'h7)
        else $error("level 7 not presented");
    a_level_one: assert property (
        (regWrite && regAddr == iprio_pkg::OFS_COMPARE_CAPTURE_A && regWrData[2:0] == 3'h1)
        |=> srcLevel[2:0] == 3'h1)
        else $error("level 1 not presented");
    a_unimpl_zero: assert property (
        regRead |=> (regRdData & ~regMask($past(regAddr))) == 16'h0000)
        else $error("unimplemented bit read nonzero");
    a_i2c_fields: assert property (
        (regWrite && regAddr == iprio_pkg::OFS_SECOND_I2C) |=>
        srcLevel[23:21] == $past(regWrData[10:8]) && srcLevel[20:18] == $past(regWrData[6:4]))
        else $error("second i2c fields misplaced");
    // write then read with no gap: the read must already see the new value
    a_cal_field: assert property (
        s_write_cal ##1 s_read_cal
        |=> regRdData == {5'h00, $past(regWrData[10:8], 2), 8'h00})
        else $error("calendar field readback wrong");
    a_uart_fields: assert property (
        (regWrite && regAddr == iprio_pkg::OFS_CRC_UART_ERRORS) |=>
        srcLevel[41:39] == $past(regWrData[14:12]) && srcLevel[38:36] == $past(regWrData[10:8])
        && srcLevel[35:33] == $past(regWrData[6:4]))
        else $error("serial error fields misplaced");
    a_reset_four: assert property (
        $rose(rst_n) |-> srcLevel[32:30] == iprio_pkg::LEVEL_RESET)
        else $error("calendar level not 4 after reset");
    a_next_cycle: assert property (
        s_write_cal |=> srcLevel[32:30] == $past(regWrData[10:8]))
        else $error("written level late");

    // every field, not only the calendar one, comes out of reset at level 4
    a_reset_all: assert property (
        $rose(rst_n) |-> srcLevel == {3'h0, {15{iprio_pkg::LEVEL_RESET}}})
        else $error("a field is not at level 4 after reset");

    // compare and capture word: four fields, one per nibble
    a_capture_fields: assert property (
        (regWrite && regAddr == iprio_pkg::OFS_COMPARE_CAPTURE_A) |=>
        srcLevel[11:0] == {$past(regWrData[14:12]), $past(regWrData[10:8]),
        $past(regWrData[6:4]), $past(regWrData[2:0])})
        else $error("compare and capture fields misplaced");

    // parallel port and the last compare channel share the low byte
    a_parallel_fields: assert property (
        (regWrite && regAddr == iprio_pkg::OFS_PARALLEL_COMPARE) |=>
        srcLevel[17:12] == {$past(regWrData[6:4]), $past(regWrData[2:0])})
        else $error("parallel port fields misplaced");

    // external pins: higher pin in 10-8, lower pin in 6-4
    a_pins_fields: assert property (
        (regWrite && regAddr == iprio_pkg::OFS_EXTERNAL_PINS_B) |=>
        srcLevel[29:24] == {$past(regWrData[10:8]), $past(regWrData[6:4])})
        else $error("external pin fields misplaced");

    // levels only move on a write, so arbitration never sees a glitch
    a_held_level: assert property (
        !regWrite |=> $stable(srcLevel))
        else $error("level changed without a write");

    // a write to the unmapped index must not land anywhere
    a_unmapped_write: assert property (
        (regWrite && regAddr == 3'h7) |=> $stable(srcLevel))
        else $error("unmapped write changed a level");

    // the unmapped index answers zero
    a_unmapped_zero: assert property (
        (regRead && regAddr == 3'h7) |=> regRdData == 16'h0000)
        else $error("unmapped index read nonzero");

    // read data stand one cycle only; a cycle without a read answers zero
    a_read_quiet: assert property (
        !regRead |=> regRdData == 16'h0000)
        else $error("read data outlived its cycle");

    // a request reaches arbitration exactly when its level is not off
    a_gate_exact: assert property (
        srcActive == (srcRequest & levelOn))
        else $error("request gating wrong");

endmodule

/* File: testbench/iprio_regs_tb_top.sv */
module iprio_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [15:0] regWrData = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] regRdData;
    logic [15:0] srcRequest = 16'h0000;
    logic [47:0] srcLevel;
    logic [15:0] srcActive;
    int n_errors = 0;
    int total_checks = 0;
    // reset image and implemented-bit image, one entry per index 0..7
    logic [15:0] resetImg [8] = '{16'h4444, 16'h0044, 16'h0440, 16'h0440,
                                  16'h0400, 16'h4440, 16'h0004, 16'h0000};
    logic [15:0] maskImg [8] = '{16'h7777, 16'h0077, 16'h0770, 16'h0770,
                                 16'h0700, 16'h7770, 16'h0007, 16'h0000};

    iprio_regs DUT (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .srcRequest(srcRequest), .srcLevel(srcLevel), .srcActive(srcActive));

    // 100 MHz clock
    always #5 clock = ~clock;

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // one-cycle write; the new value shows right after the edge that takes it
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
        #1;
    endtask

    // data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        d = regRdData;
    endtask

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // reset image, including the unmapped index
    task automatic test_reset();
        logic [15:0] v;
        chk(srcLevel, {3'h0, {15{3'h4}}});
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), v);
            chk(48'(v), 48'(resetImg[i]));
        end
    endtask

    // all ones then all zeros: only field bits stick, zero disables
    task automatic test_masks();
        logic [15:0] v;
        @(posedge clock);
        srcRequest <= 16'hffff;
        for (int i = 0; i < 8; i++) wr(3'(i), 16'hffff);
        chk(srcLevel, {3'h0, {15{3'h7}}});
        chk(48'(srcActive), 48'h7fff);
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), v);
            chk(48'(v), 48'(maskImg[i]));
        end
        for (int i = 0; i < 7; i++) wr(3'(i), 16'h0000);
        chk(srcLevel, 48'h0);
        chk(48'(srcActive), 48'h0);
    endtask

    // every code on the calendar field, each write then read back
    task automatic test_levels();
        logic [15:0] v;
        for (int lv = 0; lv < 8; lv++) begin
            wr(iprio_pkg::OFS_CALENDAR_CLOCK, {5'h1f, 3'(lv), 8'hff});
            chk(48'(srcLevel[32:30]), 48'(lv));
            chk(48'(srcActive), {47'h0, lv != 0} << 10);
            rd(iprio_pkg::OFS_CALENDAR_CLOCK, v);
            chk(48'(v), 48'(lv) << 8);
        end
        wr(iprio_pkg::OFS_CRC_UART_ERRORS, 16'h5a3c);
        rd(iprio_pkg::OFS_CRC_UART_ERRORS, v);
        chk(48'(v), 48'h5230);
        chk(48'(srcLevel[41:33]), {39'h0, 3'h5, 3'h2, 3'h3});
        wr(iprio_pkg::OFS_SECOND_I2C, 16'hf6e5);
        chk(48'(srcLevel[23:18]), {42'h0, 3'h6, 3'h6});
    endtask

    // remaining words field by field, then gating by a partial request
    task automatic test_fields();
        wr(iprio_pkg::OFS_COMPARE_CAPTURE_A, 16'h1231);
        chk(48'(srcLevel[11:0]), {36'h0, 3'h1, 3'h2, 3'h3, 3'h1});
        wr(iprio_pkg::OFS_PARALLEL_COMPARE, 16'hff65);
        chk(48'(srcLevel[17:12]), {42'h0, 3'h6, 3'h5});
        wr(iprio_pkg::OFS_EXTERNAL_PINS_B, 16'hf97f);
        chk(48'(srcLevel[29:24]), {42'h0, 3'h1, 3'h7});
        wr(iprio_pkg::OFS_LOW_VOLTAGE, 16'hfff7);
        chk(48'(srcLevel[44:42]), 48'h7);
        @(posedge clock);
        srcRequest <= 16'ha5a5;
        #1;
        chk(48'(srcActive), 48'h25a5);
        wr(iprio_pkg::OFS_PARALLEL_COMPARE, 16'h0000);
        chk(48'(srcActive), 48'h2585);
    endtask

    // write then read with no gap, a second read with no gap, then idle
    task automatic test_bus();
        @(posedge clock);
        regAddr <= iprio_pkg::OFS_CALENDAR_CLOCK;
        regWrData <= 16'hfb5f;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
        regRead <= 1'b1;
        #1;
        chk(48'(srcLevel[32:30]), 48'h3);
        @(posedge clock);
        regAddr <= iprio_pkg::OFS_EXTERNAL_PINS_B;
        #1;
        chk(48'(regRdData), 48'h0300);
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        chk(48'(regRdData), 48'h0170);
        @(posedge clock);
        #1;
        chk(48'(regRdData), 48'h0);
    endtask

    // reset in mid-run brings every field back to level 4
    task automatic test_reset_again();
        logic [15:0] v;
        @(posedge clock);
        rst_n <= 1'b0;
        #1;
        chk(srcLevel, {3'h0, {15{3'h4}}});
        chk(48'(regRdData), 48'h0);
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        chk(48'(srcActive), 48'h25a5);
        rd(iprio_pkg::OFS_CRC_UART_ERRORS, v);
        chk(48'(v), 48'h4440);
        rd(iprio_pkg::OFS_SECOND_I2C, v);
        chk(48'(v), 48'h0440);
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        test_reset();
        test_masks();
        test_levels();
        test_fields();
        test_bus();
        test_reset_again();
        end_sim();
    end

    // the whole run takes about 130 cycles; 5000 leaves wide margin
    initial begin
        #50000;
        n_errors++;
        end_sim();
    end
endmodule
